// ==== verilog/vcr_regs.sv ====
// VC0 resource configuration registers with plain register port
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps

// How it works
// [RL1] Traffic-class map is control bits 7:0, reset all ones, maps classes
// [RL2] Map bit 0 is fixed at one; bits 7:1 are read-write
// [RL3] Port arbitration select, bits 19:17, read-write, resets zero
// [RL4] Software programs only the advertised arbitration scheme
// [RL5] Port arbitration capability byte reads 0x1, round robin only
// [RL6] Channel identifier bits 26:24 always read zero
// [RL7] Channel enable bit 31 always reads one
// [RL8] Negotiation-pending status bit 17 always reads zero
// [RL9] Channel arbitration select bits 3:1 read-write, no effect
// [RL10] Load channel arbitration table bit reads zero, writes do nothing
// [RL11] Channel arbitration table status bit reads zero
// [RL12] Load port arbitration table bit 16 reads zero
// [RL13] Port arbitration table status bit 16 reads zero
// [RL14] Port arbitration table offset bits 31:24 read zero
// [RL15] Maximum time slots bits 22:16 read zero
// [RL16] Reject-snoop capability bit 15 reads zero
// [RL17] Writes to fixed or reserved bits are ignored
// [RL18] Byte-enabled half-word writes leave the other half intact
module vcr_regs
  import vcr_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              reset_in,
  input  wire logic [VCR_AW-1:0] addr_in,
  input  wire logic [VCR_DW-1:0] wdata_in,
  input  wire logic [VCR_BW-1:0] be_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [VCR_DW-1:0] rdata_out,
  output logic      [7:0]        tc_map_out,
  output logic      [2:0]        port_arb_sel_out,
  output logic      [2:0]        ch_arb_sel_out,
  output logic                   arb_unsupported_out
);

  // ----------------------------------------------------------------
  // Bus capture
  // ----------------------------------------------------------------
  vcr_bus_s bus;

  assign bus = '{addr:  addr_in,
                 wdata: wdata_in,
                 be:    be_in,
                 wr:    wr_in,
                 rd:    rd_in};

  // ----------------------------------------------------------------
  // Field write enables, one byte lane each
  // ----------------------------------------------------------------
  logic tc_wr;
  logic parb_wr;
  logic charb_wr;

  // Lane gating keeps the status half untouched by control writes
  assign tc_wr    = vcr_lane_wr(bus, VCR_RES_CTL_OFF,
                                VCR_TC_MAP_LANE); // [RL18]
  assign parb_wr  = vcr_lane_wr(bus, VCR_RES_CTL_OFF,
                                VCR_PARB_SEL_LANE); // [RL18]
  assign charb_wr = vcr_lane_wr(bus, VCR_PORT_CTL_OFF,
                                VCR_CH_ARB_LANE); // [RL18]

  // ----------------------------------------------------------------
  // Writable fields
  // ----------------------------------------------------------------
  logic [7:0] tc_map;
  logic [2:0] parb_sel;
  logic [2:0] charb_sel;

  // Bit 0 masked off so it stays at its reset one
  vcr_field #(
    .W     (VCR_TC_MAP_W),
    .RST   (VCR_TC_MAP_RST),
    .WMASK (VCR_TC_MAP_WMASK)
  ) u_tc_map (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .wr_en_in (tc_wr),
    .wdata_in (bus.wdata[VCR_TC_MAP_LSB +: VCR_TC_MAP_W]),
    .val_out  (tc_map)
  ); // [RL1] [RL2]

  vcr_field #(
    .W     (VCR_PARB_SEL_W),
    .RST   (VCR_PARB_SEL_RST),
    .WMASK (VCR_PARB_SEL_WMASK)
  ) u_parb_sel (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .wr_en_in (parb_wr),
    .wdata_in (bus.wdata[VCR_PARB_SEL_LSB +: VCR_PARB_SEL_W]),
    .val_out  (parb_sel)
  ); // [RL3]

  // Stored for readback and ch_arb_sel_out only; steers nothing
  vcr_field #(
    .W     (VCR_CH_ARB_W),
    .RST   (VCR_CH_ARB_RST),
    .WMASK (VCR_CH_ARB_WMASK)
  ) u_charb_sel (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .wr_en_in (charb_wr),
    .wdata_in (bus.wdata[VCR_CH_ARB_LSB +: VCR_CH_ARB_W]),
    .val_out  (charb_sel)
  ); // [RL9]

  // ----------------------------------------------------------------
  // Read word assembly
  // ----------------------------------------------------------------
  logic [VCR_DW-1:0] rd_word;

  vcr_rdmux u_rdmux (
    .addr_in         (addr_in),
    .tc_map_in       (tc_map),
    .port_arb_sel_in (parb_sel),
    .ch_arb_sel_in   (charb_sel),
    .word_out        (rd_word)
  ); // [RL17]

  // ----------------------------------------------------------------
  // Block state
  // ----------------------------------------------------------------
  vcr_top_state_s state_q;
  vcr_top_state_s state_d;

  always_comb begin
    state_d = state_q;
    // Read data valid only in the cycle after the strobe
    state_d.rdata = bus.rd ? rd_word : VCR_ZERO_WORD;
    // Any encoding but fixed round robin is flagged, not acted on
    state_d.arb_bad = (parb_sel != VCR_PARB_FIXED_RR); // [RL4]
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_q.rdata   <= VCR_RDATA_RST;
      state_q.arb_bad <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata_out           = state_q.rdata;
  assign arb_unsupported_out = state_q.arb_bad;
  assign tc_map_out          = tc_map;
  assign port_arb_sel_out    = parb_sel;
  assign ch_arb_sel_out      = charb_sel;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking

  default disable iff (reset_in);

  logic rd_port;
  logic rd_cap;
  logic rd_ctl;
  logic rd_sts;

  assign rd_port = rd_in && vcr_word_hit(addr_in, VCR_PORT_CTL_OFF);
  assign rd_cap  = rd_in && vcr_word_hit(addr_in, VCR_RES_CAP_OFF);
  assign rd_ctl  = rd_in && vcr_word_hit(addr_in, VCR_RES_CTL_OFF);
  assign rd_sts  = rd_in && vcr_word_hit(addr_in, VCR_RES_STS_OFF);

  sequence ctl_wr_s;
    wr_in && vcr_word_hit(addr_in, VCR_RES_CTL_OFF) && be_in[0];
  endsequence

  sequence ctl_rd_s;
    rd_ctl;
  endsequence

  tc_bit0_a: // [RL2]
  assert property (tc_map_out[0] == 1'b1)
    else $error("traffic class map bit 0 cleared");

  tc_reset_a: // [RL1]
  assert property (@(posedge clk_in) disable iff (1'b0)
    $past(reset_in) |-> tc_map_out == VCR_TC_MAP_RST)
    else $error("traffic class map not all ones after reset");

  tc_write_a: // [RL2]
  assert property (ctl_wr_s |=>
    tc_map_out[7:1] == $past(wdata_in[7:1]))
    else $error("traffic class map write not taken");

  tc_echo_a: // [RL1]
  assert property (ctl_wr_s ##1 ctl_rd_s |=>
    rdata_out[7:0] == tc_map_out)
    else $error("traffic class map readback mismatch");

  parb_reset_a: // [RL3]
  assert property (@(posedge clk_in) disable iff (1'b0)
    $past(reset_in) |-> port_arb_sel_out == VCR_PARB_SEL_RST)
    else $error("port arbitration select not zero after reset");

  parb_write_a: // [RL3]
  assert property (wr_in && vcr_word_hit(addr_in, VCR_RES_CTL_OFF)
    && be_in[2] |=> port_arb_sel_out == $past(wdata_in[19:17]))
    else $error("port arbitration select write not taken");

  arb_flag_a: // [RL4]
  assert property ((port_arb_sel_out != VCR_PARB_FIXED_RR) [*2] |->
    arb_unsupported_out)
    else $error("unsupported arbitration not flagged");

  cap_word_a: // [RL5]
  assert property (rd_cap |=> rdata_out == 32'h0000_0001)
    else $error("capability word wrong");

  ctl_fixed_a: // [RL7]
  assert property (rd_ctl |=> rdata_out[31] && rdata_out[26:24] == 3'h0
    && rdata_out[16] == 1'b0 && rdata_out[15:8] == 8'h00)
    else $error("resource control fixed bits wrong");

  sts_word_a: // [RL8]
  assert property (rd_sts |=> rdata_out == VCR_ZERO_WORD)
    else $error("resource status word not zero");

  port_word_a: // [RL9]
  assert property (rd_port |=> rdata_out[0] == 1'b0
    && rdata_out[3:1] == ch_arb_sel_out && rdata_out[31:4] == 28'h0)
    else $error("port control and status word wrong");

  half_write_a: // [RL18]
  assert property (wr_in && !be_in[0] |=> $stable(ch_arb_sel_out)
    && $stable(tc_map_out))
    else $error("write without lane 0 changed a field");

  idle_zero_a: // [RL17]
  assert property (!rd_in |=> rdata_out == VCR_ZERO_WORD)
    else $error("read data not zero outside read reply");

  // ----------------------------------------------------------------
  // Field hold and write checks
  // ----------------------------------------------------------------
  logic wr_ctl;
  logic wr_port;

  assign wr_ctl  = wr_in && vcr_word_hit(addr_in, VCR_RES_CTL_OFF);
  assign wr_port = wr_in && vcr_word_hit(addr_in, VCR_PORT_CTL_OFF);

  sequence port_wr_s;
    wr_port && be_in[VCR_CH_ARB_LANE];
  endsequence

  sequence parb_wr_s;
    wr_ctl && be_in[VCR_PARB_SEL_LANE];
  endsequence

  tc_hold_a: // [RL17]
  assert property (!(wr_ctl && be_in[VCR_TC_MAP_LANE]) |=>
    $stable(tc_map_out))
    else $error("traffic class map changed without a write");

  parb_hold_a: // [RL3]
  assert property (!(wr_ctl && be_in[VCR_PARB_SEL_LANE]) |=>
    $stable(port_arb_sel_out))
    else $error("port arbitration select changed without a write");

  charb_hold_a: // [RL9]
  assert property (!(wr_port && be_in[VCR_CH_ARB_LANE]) |=>
    $stable(ch_arb_sel_out))
    else $error("channel arbitration select changed without a write");

  charb_write_a: // [RL9]
  assert property (port_wr_s |=>
    ch_arb_sel_out == $past(wdata_in[VCR_CH_ARB_LSB +: VCR_CH_ARB_W]))
    else $error("channel arbitration select write not taken");

  parb_echo_a: // [RL3]
  assert property (parb_wr_s ##1 ctl_rd_s |=>
    rdata_out[VCR_PARB_SEL_LSB +: VCR_PARB_SEL_W] == port_arb_sel_out)
    else $error("port arbitration select readback mismatch");

  arb_set_a: // [RL4]
  assert property (port_arb_sel_out != VCR_PARB_FIXED_RR |=>
    arb_unsupported_out)
    else $error("unsupported arbitration flag late");

  arb_clear_a: // [RL4]
  assert property (port_arb_sel_out == VCR_PARB_FIXED_RR |=>
    !arb_unsupported_out)
    else $error("unsupported arbitration flag not cleared");

  // ----------------------------------------------------------------
  // Read word field checks
  // ----------------------------------------------------------------
  port_load_a: // [RL10]
  assert property (rd_port |=> rdata_out[VCR_LOAD_CH_ARB_BIT] == 1'b0)
    else $error("load channel arbitration table bit set");

  port_sts_a: // [RL11]
  assert property (rd_port |=>
    rdata_out[VCR_PORT_STS_LSB + VCR_CH_ARB_STS_BIT] == 1'b0)
    else $error("channel arbitration table status bit set");

  cap_parb_a: // [RL5]
  assert property (rd_cap |=>
    rdata_out[VCR_PARB_CAP_LSB +: 8] == VCR_PARB_CAP_VAL)
    else $error("port arbitration capability byte wrong");

  cap_snoop_a: // [RL16]
  assert property (rd_cap |=>
    rdata_out[VCR_REJ_SNOOP_BIT] == VCR_REJ_SNOOP_VAL)
    else $error("reject snoop capability bit wrong");

  cap_slots_a: // [RL15]
  assert property (rd_cap |=>
    rdata_out[VCR_MAX_TS_LSB +: 7] == VCR_MAX_TS_VAL)
    else $error("maximum time slots field wrong");

  cap_offset_a: // [RL14]
  assert property (rd_cap |=>
    rdata_out[VCR_PATBL_OFF_LSB +: 8] == VCR_PATBL_OFF_VAL)
    else $error("port arbitration table offset wrong");

  ctl_map_a: // [RL1]
  assert property (rd_ctl |=>
    rdata_out[VCR_TC_MAP_LSB +: VCR_TC_MAP_W] == tc_map_out)
    else $error("traffic class map read wrong");

  ctl_id_a: // [RL6]
  assert property (rd_ctl |=>
    rdata_out[VCR_CH_ID_LSB +: 3] == VCR_CH_ID_VAL)
    else $error("channel identifier not zero");

  ctl_load_a: // [RL12]
  assert property (rd_ctl |=> rdata_out[VCR_LOAD_PARB_BIT] == 1'b0)
    else $error("load port arbitration table bit set");

  ctl_enable_a: // [RL7]
  assert property (rd_ctl |=> rdata_out[VCR_CH_EN_BIT] == VCR_CH_EN_VAL)
    else $error("channel enable bit not set");

  ctl_rsvd_a: // [RL17]
  assert property (rd_ctl |=> rdata_out[30:27] == 4'h0
    && rdata_out[23:20] == 4'h0)
    else $error("resource control reserved bits set");

  sts_table_a: // [RL13]
  assert property (rd_sts |=> rdata_out[VCR_PARB_TBL_STS_BIT] == 1'b0)
    else $error("port arbitration table status bit set");

  sts_neg_a: // [RL8]
  assert property (rd_sts |=> rdata_out[VCR_NEG_PEND_BIT] == 1'b0)
    else $error("negotiation pending bit set");

endmodule

// ==== verilog/vcr_pkg.sv ====
// Constants, carriers and helpers for the VC0 resource register set
package vcr_pkg;

  // ----------------------------------------------------------------
  // Bus widths
  // ----------------------------------------------------------------
  localparam int VCR_AW = 12;
  localparam int VCR_DW = 32;
  localparam int VCR_BW = 4;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] VCR_PORT_CTL_OFF = 12'h20c;
  localparam logic [11:0] VCR_PORT_STS_OFF = 12'h20e;
  localparam logic [11:0] VCR_RES_CAP_OFF  = 12'h210;
  localparam logic [11:0] VCR_RES_CTL_OFF  = 12'h214;
  localparam logic [11:0] VCR_RES_STS_OFF  = 12'h218;

  // ----------------------------------------------------------------
  // Port control / status word (status is the upper half)
  // ----------------------------------------------------------------
  localparam int          VCR_LOAD_CH_ARB_BIT = 0;
  localparam int          VCR_CH_ARB_LSB      = 1;
  localparam int          VCR_CH_ARB_W        = 3;
  localparam logic [2:0]  VCR_CH_ARB_RST      = 3'h0;
  localparam logic [2:0]  VCR_CH_ARB_WMASK    = 3'h7;
  localparam logic [1:0]  VCR_CH_ARB_LANE     = 2'h0;
  localparam int          VCR_PORT_STS_LSB    = 16;
  localparam int          VCR_CH_ARB_STS_BIT  = 0;

  // ----------------------------------------------------------------
  // Resource capability word
  // ----------------------------------------------------------------
  localparam int          VCR_PARB_CAP_LSB    = 0;
  localparam logic [7:0]  VCR_PARB_CAP_VAL    = 8'h01;
  localparam int          VCR_REJ_SNOOP_BIT   = 15;
  localparam logic        VCR_REJ_SNOOP_VAL   = 1'h0;
  localparam int          VCR_MAX_TS_LSB      = 16;
  localparam logic [6:0]  VCR_MAX_TS_VAL      = 7'h00;
  localparam int          VCR_PATBL_OFF_LSB   = 24;
  localparam logic [7:0]  VCR_PATBL_OFF_VAL   = 8'h00;

  // ----------------------------------------------------------------
  // Resource control word
  // ----------------------------------------------------------------
  localparam int          VCR_TC_MAP_LSB      = 0;
  localparam int          VCR_TC_MAP_W        = 8;
  localparam logic [7:0]  VCR_TC_MAP_RST      = 8'hff;
  localparam logic [7:0]  VCR_TC_MAP_WMASK    = 8'hfe;
  localparam logic [1:0]  VCR_TC_MAP_LANE     = 2'h0;
  localparam int          VCR_LOAD_PARB_BIT   = 16;
  localparam int          VCR_PARB_SEL_LSB    = 17;
  localparam int          VCR_PARB_SEL_W      = 3;
  localparam logic [2:0]  VCR_PARB_SEL_RST    = 3'h0;
  localparam logic [2:0]  VCR_PARB_SEL_WMASK  = 3'h7;
  localparam logic [2:0]  VCR_PARB_FIXED_RR   = 3'h0;
  localparam logic [1:0]  VCR_PARB_SEL_LANE   = 2'h2;
  localparam int          VCR_CH_ID_LSB       = 24;
  localparam logic [2:0]  VCR_CH_ID_VAL       = 3'h0;
  localparam int          VCR_CH_EN_BIT       = 31;
  localparam logic        VCR_CH_EN_VAL       = 1'h1;

  // ----------------------------------------------------------------
  // Resource status word
  // ----------------------------------------------------------------
  localparam int          VCR_PARB_TBL_STS_BIT = 16;
  localparam int          VCR_NEG_PEND_BIT     = 17;

  localparam logic [31:0] VCR_RDATA_RST = 32'h0000_0000;
  localparam logic [31:0] VCR_ZERO_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [VCR_AW-1:0] addr;
    logic [VCR_DW-1:0] wdata;
    logic [VCR_BW-1:0] be;
    logic              wr;
    logic              rd;
  } vcr_bus_s;

  typedef struct packed {
    logic [VCR_DW-1:0] rdata;
    logic              arb_bad;
  } vcr_top_state_s;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic vcr_word_hit(input logic [11:0] addr,
                                        input logic [11:0] off);
    return addr[11:2] == off[11:2];
  endfunction

  function automatic logic vcr_lane_wr(input vcr_bus_s   bus,
                                       input logic [11:0] off,
                                       input logic [1:0]  lane);
    return bus.wr && vcr_word_hit(bus.addr, off) && bus.be[lane];
  endfunction

endpackage

// ==== verilog/vcr_field.sv ====
// One software-writable field with a per-bit write mask
`timescale 1ns/1ps
module vcr_field
  import vcr_pkg::*;
#(
  parameter int           W     = 8,
  parameter logic [W-1:0] RST   = '0,
  parameter logic [W-1:0] WMASK = '1
) (
  input  wire logic         clk_in,
  input  wire logic         reset_in,
  input  wire logic         wr_en_in,
  input  wire logic [W-1:0] wdata_in,
  output logic      [W-1:0] val_out
);

  typedef struct packed {
    logic [W-1:0] val;
  } vcr_field_state_s;

  vcr_field_state_s state_q;
  vcr_field_state_s state_d;

  // ----------------------------------------------------------------
  // Next state: masked bits keep their value
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    if (wr_en_in) begin
      state_d.val = (wdata_in & WMASK) | (state_q.val & ~WMASK);
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_q.val <= RST;
    end else begin
      state_q <= state_d;
    end
  end

  assign val_out = state_q.val;

endmodule

// ==== verilog/vcr_rdmux.sv ====
// Read word assembly for the VC0 resource register set
`timescale 1ns/1ps
module vcr_rdmux
  import vcr_pkg::*;
(
  input  wire logic [VCR_AW-1:0] addr_in,
  input  wire logic [7:0]        tc_map_in,
  input  wire logic [2:0]        port_arb_sel_in,
  input  wire logic [2:0]        ch_arb_sel_in,
  output logic      [VCR_DW-1:0] word_out
);

  // ----------------------------------------------------------------
  // Fixed fields are constants, reserved bits zero
  // ----------------------------------------------------------------
  always_comb begin
    word_out = VCR_ZERO_WORD;
    if (vcr_word_hit(addr_in, VCR_PORT_CTL_OFF)) begin
      word_out[VCR_LOAD_CH_ARB_BIT] = 1'b0; // [RL10]
      word_out[VCR_CH_ARB_LSB +: VCR_CH_ARB_W] = ch_arb_sel_in; // [RL9]
      word_out[VCR_PORT_STS_LSB + VCR_CH_ARB_STS_BIT] = 1'b0; // [RL11]
    end else if (vcr_word_hit(addr_in, VCR_RES_CAP_OFF)) begin
      word_out[VCR_PARB_CAP_LSB +: 8] = VCR_PARB_CAP_VAL; // [RL5]
      word_out[VCR_REJ_SNOOP_BIT] = VCR_REJ_SNOOP_VAL; // [RL16]
      word_out[VCR_MAX_TS_LSB +: 7] = VCR_MAX_TS_VAL; // [RL15]
      word_out[VCR_PATBL_OFF_LSB +: 8] = VCR_PATBL_OFF_VAL; // [RL14]
    end else if (vcr_word_hit(addr_in, VCR_RES_CTL_OFF)) begin
      word_out[VCR_TC_MAP_LSB +: VCR_TC_MAP_W] = tc_map_in; // [RL1]
      word_out[VCR_LOAD_PARB_BIT] = 1'b0; // [RL12]
      word_out[VCR_PARB_SEL_LSB +: VCR_PARB_SEL_W] = port_arb_sel_in; // [RL3]
      word_out[VCR_CH_ID_LSB +: 3] = VCR_CH_ID_VAL; // [RL6]
      word_out[VCR_CH_EN_BIT] = VCR_CH_EN_VAL; // [RL7]
    end else if (vcr_word_hit(addr_in, VCR_RES_STS_OFF)) begin
      word_out[VCR_PARB_TBL_STS_BIT] = 1'b0; // [RL13]
      word_out[VCR_NEG_PEND_BIT] = 1'b0; // [RL8]
    end
  end

endmodule

// ==== dv/vcr_tb.sv ====
// Self-checking testbench for the VC0 resource register set
`timescale 1ns/1ps
module testbench
  import vcr_pkg::*;
;
  logic              clk_in;
  logic              reset_in;
  logic [VCR_AW-1:0] addr_in;
  logic [VCR_DW-1:0] wdata_in;
  logic [VCR_BW-1:0] be_in;
  logic              wr_in;
  logic              rd_in;
  logic [VCR_DW-1:0] rdata_out;
  logic [7:0]        tc_map_out;
  logic [2:0]        port_arb_sel_out;
  logic [2:0]        ch_arb_sel_out;
  logic              arb_unsupported_out;
  int                num_errors;
  int                n_tests;
  int                seed;
  int                m_tc;
  int                m_parb;
  int                m_charb;
  logic [11:0]       addrs [7];

  vcr_regs i_dut (
    .clk_in              (clk_in),
    .reset_in            (reset_in),
    .addr_in             (addr_in),
    .wdata_in            (wdata_in),
    .be_in               (be_in),
    .wr_in               (wr_in),
    .rd_in               (rd_in),
    .rdata_out           (rdata_out),
    .tc_map_out          (tc_map_out),
    .port_arb_sel_out    (port_arb_sel_out),
    .ch_arb_sel_out      (ch_arb_sel_out),
    .arb_unsupported_out (arb_unsupported_out)
  );

  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  function automatic logic [31:0] exp_word(input logic [11:0] a);
    case (a[11:2])
      10'h083: return {28'h0000000, m_charb[2:0], 1'b0};
      10'h084: return 32'h0000_0001;
      10'h085: return {1'b1, 11'h000, m_parb[2:0], 9'h000, m_tc[7:0]};
      default: return 32'h0000_0000;
    endcase
  endfunction

  task automatic model_reset();
    m_tc    = 255;
    m_parb  = 0;
    m_charb = 0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic check_outs();
    chk({24'h0, tc_map_out}, m_tc, "tc map");
    chk({29'h0, port_arb_sel_out}, m_parb, "p sel");
    chk({29'h0, ch_arb_sel_out}, m_charb, "c sel");
  endtask

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic do_wr(input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] b);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    be_in    <= b;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    if (a[11:2] == 10'h085 && b[0]) m_tc = d[7:0] | 8'h01;
    if (a[11:2] == 10'h085 && b[2]) m_parb = d[19:17];
    if (a[11:2] == 10'h083 && b[0]) m_charb = d[3:1];
    @(negedge clk_in);
    check_outs();
    @(negedge clk_in);
    chk(arb_unsupported_out, m_parb != 0, "arb flag");
  endtask

  task automatic do_rd(input logic [11:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    chk(rdata_out, exp_word(a), "read");
    @(negedge clk_in);
    chk(rdata_out, 32'h0, "idle");
  endtask

  task automatic end_test(input string name);
    $display("test %s done, errors %0d", name, num_errors);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, reset and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  initial begin
    repeat (100000) @(posedge clk_in);
    num_errors++;
    $display("[ERR] %0t watchdog got %h exp %h", $time, 1'b1, 1'b0);
    close_out();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_in = 1'b1;
    addr_in  = '0;
    wdata_in = '0;
    be_in    = '0;
    wr_in    = 1'b0;
    rd_in    = 1'b0;
    seed     = 23441;
    addrs    = '{12'h20c, 12'h20e, 12'h210, 12'h214, 12'h218, 12'h21c,
                 12'h200};
    model_reset();
    repeat (8) @(posedge clk_in);
    reset_in <= 1'b0;
    @(negedge clk_in);
    check_outs();
    do_rd(12'h20c);
    do_rd(12'h20e);
    do_rd(12'h210);
    do_rd(12'h214);
    do_rd(12'h218);
    do_rd(12'h21c);
    end_test("reset values");

    do_wr(12'h214, 32'h0000_0a00, 4'hf);
    do_rd(12'h214);
    foreach (addrs[i]) do_wr(addrs[i], 32'hffff_ffff, 4'hf);
    foreach (addrs[i]) do_rd(addrs[i]);
    do_wr(12'h214, 32'h0000_0000, 4'hf);
    do_rd(12'h214);
    end_test("fixed bits");

    do_wr(12'h214, 32'h00fe_00aa, 4'h4);
    do_wr(12'h214, 32'h000e_0010, 4'h1);
    do_wr(12'h20e, 32'h0000_000e, 4'hc);
    do_wr(12'h20e, 32'h0000_000a, 4'h1);
    do_rd(12'h20c);
    do_rd(12'h214);
    end_test("byte lanes");

    for (int k = 7; k >= 0; k--) begin
      do_wr(12'h214, k << 17, 4'h4);
      do_rd(12'h214);
    end
    end_test("arb codes");

    @(posedge clk_in);
    addr_in  <= 12'h214;
    wdata_in <= 32'h0000_0054;
    be_in    <= 4'h5;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b1;
    m_tc  = 8'h55;
    m_parb = 0;
    @(posedge clk_in);
    addr_in <= 12'h210;
    @(negedge clk_in);
    chk(rdata_out, exp_word(12'h214), "b2b wr rd");
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    chk(rdata_out, exp_word(12'h210), "b2b rd rd");
    end_test("back to back");

    repeat (200) begin
      automatic logic [11:0] a = addrs[{$random(seed)} % 7];
      automatic logic [31:0] d = $random(seed);
      automatic logic [3:0]  b = 4'($random(seed));
      if ($random(seed) & 1) do_wr(a, d, b);
      else do_rd(a);
    end
    end_test("random");

    do_wr(12'h214, 32'h000a_0000, 4'hf);
    do_wr(12'h20c, 32'h0000_0006, 4'h1);
    @(posedge clk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    model_reset();
    @(negedge clk_in);
    check_outs();
    chk(arb_unsupported_out, 1'b0, "arb flag");
    do_rd(12'h214);
    end_test("mid reset");
    close_out();
  end
endmodule
